// >>> hw/pcs_pkg.sv
// constants, register map and state codes of the process context switch sequencer
// assumes a byte-wide memory port with a one-cycle acknowledge on the sequencer clock
package pcs_pkg;
   localparam logic [7:0]  REG_ORIGIN    = 8'h00;
   localparam logic [7:0]  REG_UPPER     = 8'h04;
   localparam logic [7:0]  REG_CTRL_WORD = 8'h08;
   localparam logic [7:0]  REG_PROG_CNT  = 8'h0C;
   localparam logic [7:0]  REG_PRIMARY   = 8'h10;
   localparam logic [7:0]  REG_STACK_TOP = 8'h14;
   localparam logic [7:0]  REG_OPERAND   = 8'h18;
   localparam logic [7:0]  REG_CMD_STAT  = 8'h1C;

   localparam logic [15:0] ORIGIN_RST    = 16'h0000;
   localparam logic [15:0] UPPER_RST     = 16'hFFFF;
   localparam logic [15:0] CTRL_WORD_RST = 16'h0003;
   localparam int          CW_KERNEL_BIT = 0;
   localparam int          CW_SUPER_BIT  = 1;

   localparam logic [23:0] RESET_VEC_ADR = 24'hFF_FFFC;
   localparam logic [23:0] CALLER_PTR    = 24'h00_0000;
   localparam logic [3:0]  VEC_BYTES     = 4'h4;
   localparam logic [3:0]  PTR_BYTES     = 4'h3;
   localparam logic [3:0]  PUSH_BYTES    = 4'hC;
   localparam logic [3:0]  LIST_MAX      = 4'hF;
   localparam logic [7:0]  LEN_WITH_STK  = 8'h0A;
   localparam logic [7:0]  LEN_WITH_CW   = 8'h0C;
   localparam logic [7:0]  LEN_WITH_PRM  = 8'h0F;

   localparam int          ST_GO_BIT     = 0;
   localparam int          ST_BUSY_BIT   = 0;
   localparam int          ST_REJ_BIT    = 1;

   typedef enum logic [3:0] {
      S_VEC   = 4'b0000,
      S_IDLE  = 4'b0001,
      S_PUSH  = 4'b0010,
      S_LRD   = 4'b0011,
      S_LWR   = 4'b0100,
      S_PTR   = 4'b0101,
      S_LEN   = 4'b0110,
      S_LIST  = 4'b0111,
      S_LOAD  = 4'b1000
   } pcs_state_t;
endpackage

// >>> hw/pcs_sequencer.sv
// process context switch sequencer: reset vector fetch and invoke-process sequence
// assumes memory answers each request with mem_ack_i on clk_sys_i; register port is same-clock logic
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
module pcs_sequencer
(
   input  wire logic                      clk_sys_i,
   input  wire logic                      rst_i,
   input  wire logic                      ce_i,
   input  wire logic [7:0]                reg_addr_i,
   input  wire logic [31:0]               reg_wdata_i,
   input  wire logic                      reg_wr_i,
   input  wire logic                      reg_rd_i,
   output logic      [31:0]               reg_rdata_o,
   output logic      [23:0]               mem_addr_o,
   output logic      [7:0]                mem_wdata_o,
   output logic                           mem_we_o,
   output logic                           mem_req_o,
   input  wire logic [7:0]                mem_rdata_i,
   input  wire logic                      mem_ack_i,
   output logic                           busy_o
);
   import pcs_pkg::*;

   pcs_state_t  state_ff;
   logic [3:0]  step_ff;
   logic        req_ff;
   logic        we_ff;
   logic [23:0] addr_ff;
   logic [7:0]  wdata_ff;
   logic [31:0] rdata_ff;
   logic        rej_ff;

   logic [15:0] process_origin_page_ff;
   logic [15:0] process_upper_bound_page_ff;
   logic [15:0] process_control_word_ff;
   logic [23:0] process_program_counter_ff;
   logic [23:0] primary_pointer_register_ff;
   logic [23:0] stack_top_register_ff;
   logic [23:0] operand_ff;
   logic [23:0] list_addr_ff;
   logic [7:0]  list_len_ff;
   logic [23:0] tmp_ff;
   logic [7:0]  lst_ff [1:15];

   logic [95:0] ctx;
   logic [7:0]  push_byte;
   logic [23:0] cur_origin_adr;
   logic        acked;
   logic        sw_wr;
   logic [15:0] nxt_origin;
   logic [23:0] nxt_origin_adr;
   logic        privileged;

   // snapshot of the caller, packed so that byte 0 is the lowest stacked byte
   assign ctx = {process_control_word_ff, primary_pointer_register_ff, process_program_counter_ff,
                 process_upper_bound_page_ff, process_origin_page_ff};
   // pushes run from the top down, so the first byte written is the highest
   assign push_byte      = ctx[8 * (11 - int'(step_ff)) +: 8];
   assign cur_origin_adr = {process_origin_page_ff, 8'h00};
   assign acked          = req_ff && mem_ack_i;
   assign sw_wr          = reg_wr_i && (state_ff == S_IDLE);
   assign nxt_origin     = process_origin_page_ff + {lst_ff[2], lst_ff[1]};
   assign nxt_origin_adr = {nxt_origin, 8'h00};
   assign privileged     = process_control_word_ff[CW_KERNEL_BIT] || process_control_word_ff[CW_SUPER_BIT];

   // sequencer, memory requests and process registers share one owner
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_ff                    <= S_VEC;
         step_ff                     <= 4'h0;
         req_ff                      <= 1'b0;
         we_ff                       <= 1'b0;
         addr_ff                     <= 24'h00_0000;
         wdata_ff                    <= 8'h00;
         rej_ff                      <= 1'b0;
         process_origin_page_ff      <= ORIGIN_RST;
         process_upper_bound_page_ff <= UPPER_RST;
         process_control_word_ff     <= CTRL_WORD_RST;
         process_program_counter_ff  <= 24'h00_0000;
         primary_pointer_register_ff <= 24'h00_0000;
         stack_top_register_ff       <= 24'h00_0000;
         operand_ff                  <= 24'h00_0000;
         list_addr_ff                <= 24'h00_0000;
         list_len_ff                 <= 8'h00;
         tmp_ff                      <= 24'h00_0000;
         for (int i = 1; i <= 15; i++)
         begin
            lst_ff[i] <= 8'h00;
         end
      end
      else if (ce_i)
      begin
         case (state_ff)
            S_VEC:
            begin
               if (!req_ff)
               begin
                  req_ff  <= 1'b1;
                  we_ff   <= 1'b0;
                  addr_ff <= RESET_VEC_ADR + {20'h0_0000, step_ff};
               end
               else if (acked)
               begin
                  req_ff <= 1'b0;
                  // the fourth vector byte carries no address bits and is dropped
                  if (step_ff < PTR_BYTES)
                  begin
                     tmp_ff[8 * int'(step_ff) +: 8] <= mem_rdata_i;
                  end
                  if (step_ff == VEC_BYTES - 4'h1)
                  begin
                     process_program_counter_ff <= tmp_ff;
                     state_ff                   <= S_IDLE;
                     step_ff                    <= 4'h0;
                  end
                  else
                  begin
                     step_ff <= step_ff + 4'h1;
                  end
               end
            end
            S_IDLE:
            begin
               if (sw_wr)
               begin
                  case (reg_addr_i)
                     REG_ORIGIN:    process_origin_page_ff      <= reg_wdata_i[15:0];
                     REG_UPPER:     process_upper_bound_page_ff <= reg_wdata_i[15:0];
                     REG_CTRL_WORD: process_control_word_ff     <= reg_wdata_i[15:0];
                     REG_PROG_CNT:  process_program_counter_ff  <= reg_wdata_i[23:0];
                     REG_PRIMARY:   primary_pointer_register_ff <= reg_wdata_i[23:0];
                     REG_STACK_TOP: stack_top_register_ff       <= reg_wdata_i[23:0];
                     REG_OPERAND:   operand_ff                  <= reg_wdata_i[23:0];
                     REG_CMD_STAT:
                     begin
                        if (reg_wdata_i[ST_GO_BIT])
                        begin
                           // user process cannot invoke, so no link area
                           if (privileged)
                           begin
                              list_addr_ff <= operand_ff;
                              rej_ff       <= 1'b0;
                              state_ff     <= S_PUSH;
                              step_ff      <= 4'h0;
                           end
                           else
                           begin
                              rej_ff <= 1'b1;
                           end
                        end
                     end
                     default:
                     begin
                     end
                  endcase
               end
            end
            S_PUSH:
            begin
               if (!req_ff)
               begin
                  stack_top_register_ff <= stack_top_register_ff - 24'h00_0001;
                  addr_ff  <= stack_top_register_ff - 24'h00_0001;
                  wdata_ff <= push_byte;
                  we_ff    <= 1'b1;
                  req_ff   <= 1'b1;
               end
               else if (acked)
               begin
                  req_ff <= 1'b0;
                  if (step_ff == PUSH_BYTES - 4'h1)
                  begin
                     state_ff <= S_LRD;
                     step_ff  <= 4'h0;
                  end
                  else
                  begin
                     step_ff <= step_ff + 4'h1;
                  end
               end
            end
            S_LRD:
            begin
               if (!req_ff)
               begin
                  addr_ff <= CALLER_PTR + {20'h0_0000, step_ff};
                  we_ff   <= 1'b0;
                  req_ff  <= 1'b1;
               end
               else if (acked)
               begin
                  req_ff                         <= 1'b0;
                  tmp_ff[8 * int'(step_ff) +: 8] <= mem_rdata_i;
                  if (step_ff == PTR_BYTES - 4'h1)
                  begin
                     state_ff <= S_LWR;
                     step_ff  <= 4'h0;
                  end
                  else
                  begin
                     step_ff <= step_ff + 4'h1;
                  end
               end
            end
            S_LWR:
            begin
               if (!req_ff)
               begin
                  addr_ff  <= cur_origin_adr + {20'h0_0000, step_ff};
                  wdata_ff <= tmp_ff[8 * int'(step_ff) +: 8];
                  we_ff    <= 1'b1;
                  req_ff   <= 1'b1;
               end
               else if (acked)
               begin
                  req_ff <= 1'b0;
                  if (step_ff == PTR_BYTES - 4'h1)
                  begin
                     state_ff <= S_PTR;
                     step_ff  <= 4'h0;
                  end
                  else
                  begin
                     step_ff <= step_ff + 4'h1;
                  end
               end
            end
            S_PTR:
            begin
               if (!req_ff)
               begin
                  addr_ff  <= CALLER_PTR + {20'h0_0000, step_ff};
                  wdata_ff <= stack_top_register_ff[8 * int'(step_ff) +: 8];
                  we_ff    <= 1'b1;
                  req_ff   <= 1'b1;
               end
               else if (acked)
               begin
                  req_ff <= 1'b0;
                  if (step_ff == PTR_BYTES - 4'h1)
                  begin
                     state_ff <= S_LEN;
                     step_ff  <= 4'h0;
                  end
                  else
                  begin
                     step_ff <= step_ff + 4'h1;
                  end
               end
            end
            S_LEN:
            begin
               if (!req_ff)
               begin
                  addr_ff <= list_addr_ff;
                  we_ff   <= 1'b0;
                  req_ff  <= 1'b1;
               end
               else if (acked)
               begin
                  req_ff      <= 1'b0;
                  list_len_ff <= mem_rdata_i;
                  state_ff    <= S_LIST;
                  step_ff     <= 4'h1;
               end
            end
            S_LIST:
            begin
               if ({4'h0, step_ff} > list_len_ff)
               begin
                  state_ff <= S_LOAD;
               end
               else if (!req_ff)
               begin
                  addr_ff <= list_addr_ff + {20'h0_0000, step_ff};
                  we_ff   <= 1'b0;
                  req_ff  <= 1'b1;
               end
               else if (acked)
               begin
                  req_ff                <= 1'b0;
                  lst_ff[int'(step_ff)] <= mem_rdata_i;
                  // bytes past the last known entry are not read
                  if (step_ff == LIST_MAX)
                  begin
                     state_ff <= S_LOAD;
                  end
                  else
                  begin
                     step_ff <= step_ff + 4'h1;
                  end
               end
            end
            S_LOAD:
            begin
               process_origin_page_ff      <= nxt_origin;
               process_upper_bound_page_ff <= nxt_origin + {lst_ff[4], lst_ff[3]};
               process_program_counter_ff  <= nxt_origin_adr + {lst_ff[7], lst_ff[6], lst_ff[5]};
               if (list_len_ff >= LEN_WITH_STK)
               begin
                  stack_top_register_ff <= nxt_origin_adr + {lst_ff[10], lst_ff[9], lst_ff[8]};
               end
               if (list_len_ff >= LEN_WITH_CW)
               begin
                  process_control_word_ff <= {lst_ff[12], lst_ff[11]};
               end
               if (list_len_ff >= LEN_WITH_PRM)
               begin
                  primary_pointer_register_ff <= nxt_origin_adr + {lst_ff[15], lst_ff[14], lst_ff[13]};
               end
               state_ff <= S_IDLE;
               step_ff  <= 4'h0;
            end
            default:
            begin
               state_ff <= S_IDLE;
               req_ff   <= 1'b0;
            end
         endcase
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rdata_ff <= 32'h0000_0000;
      end
      else if (ce_i)
      begin
         rdata_ff <= 32'h0000_0000;
         if (reg_rd_i)
         begin
            case (reg_addr_i)
               REG_ORIGIN:    rdata_ff <= {16'h0000, process_origin_page_ff};
               REG_UPPER:     rdata_ff <= {16'h0000, process_upper_bound_page_ff};
               REG_CTRL_WORD: rdata_ff <= {16'h0000, process_control_word_ff};
               REG_PROG_CNT:  rdata_ff <= {8'h00, process_program_counter_ff};
               REG_PRIMARY:   rdata_ff <= {8'h00, primary_pointer_register_ff};
               REG_STACK_TOP: rdata_ff <= {8'h00, stack_top_register_ff};
               REG_OPERAND:   rdata_ff <= {8'h00, operand_ff};
               REG_CMD_STAT:  rdata_ff <= {30'h0000_0000, rej_ff, state_ff != S_IDLE};
               default:       rdata_ff <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign reg_rdata_o = rdata_ff;
   assign mem_addr_o  = addr_ff;
   assign mem_wdata_o = wdata_ff;
   assign mem_we_o    = we_ff;
   assign mem_req_o   = req_ff;

   // busy flop mirrors the sequencer, so the output comes straight from a register
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         busy_o <= 1'b1;
      end
      else if (ce_i)
      begin
         busy_o <= !((state_ff == S_IDLE && !(sw_wr && reg_addr_i == REG_CMD_STAT && reg_wdata_i[ST_GO_BIT]
                     && privileged)) || state_ff == S_LOAD);
      end
   end
endmodule

// >>> tb/pcs_sequencer_props.sv
// checker for the sequencer ports: memory handshake, read port, vector fetch, caller pointer
// assumes one clock domain; bound to every pcs_sequencer instance by the bind below
`timescale 1ns/1ns
module pcs_sequencer_props
(
   input  wire logic        clk_sys_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic        reg_rd_i,
   input  wire logic [31:0] reg_rdata_o,
   input  wire logic [23:0] mem_addr_o,
   input  wire logic [7:0]  mem_wdata_o,
   input  wire logic        mem_we_o,
   input  wire logic        mem_req_o,
   input  wire logic        mem_ack_i,
   input  wire logic        busy_o
);
   logic idle_ff;

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);

   sequence s_take(logic [23:0] a, logic w);
      mem_req_o && mem_ack_i && mem_we_o == w && mem_addr_o == a;
   endsequence
   sequence s_ask(logic [23:0] a, logic w);
      mem_req_o && mem_we_o == w && mem_addr_o == a;
   endsequence

   // remembers a quiet stretch so the first request of an invoke can be told apart
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
         idle_ff <= 1'b0;
      else if (mem_req_o)
         idle_ff <= 1'b0;
      else if (!busy_o)
         idle_ff <= 1'b1;
   end

   a_req_held_stable: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o)
      && $stable(mem_we_o) && $stable(mem_wdata_o)) else $error("request changed before ack");
   a_req_drop_after: assert property (mem_req_o && mem_ack_i |=> !mem_req_o)
      else $error("request not dropped after ack");
   a_rdata_zero_idle: assert property (!($past(reg_rd_i) && $past(ce_i)) |-> reg_rdata_o == 32'h0000_0000)
      else $error("read data not zero outside read answer");
   a_vec_first_read: assert property ($fell(rst_i) |-> ##[0:2] s_ask(24'hFF_FFFC, 1'b0))
      else $error("vector fetch not started");
   a_vec_next_byte: assert property (s_take(24'hFF_FFFC, 1'b0) |-> ##2 s_ask(24'hFF_FFFD, 1'b0))
      else $error("vector byte order wrong");
   a_ptr_read_order: assert property (s_take(24'h00_0000, 1'b0) |-> ##2 s_ask(24'h00_0001, 1'b0))
      else $error("caller pointer read order wrong");
   a_ptr_write_order: assert property (s_take(24'h00_0000, 1'b1) |-> ##2 s_ask(24'h00_0001, 1'b1))
      else $error("caller pointer write order wrong");
   a_idle_no_req: assert property (!busy_o && !$past(busy_o) |-> !mem_req_o)
      else $error("memory traffic while idle");
   a_push_opens: assert property ($rose(mem_req_o) && idle_ff |-> mem_we_o)
      else $error("invoke does not open with a push");
endmodule

bind pcs_sequencer pcs_sequencer_props i_props (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
   .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
   .mem_we_o(mem_we_o), .mem_req_o(mem_req_o), .mem_ack_i(mem_ack_i), .busy_o(busy_o));

// >>> tb/pcs_sequencer_bench.sv
// self-checking bench for the sequencer: byte memory model, register tasks, scenarios
// assumes pcs_pkg and the checker file are compiled before this one
`timescale 1ns/1ns
module pcs_sequencer_bench;
   import pcs_pkg::*;
   // parameter list sits well away from the caller pointer bytes
   localparam logic [23:0] LST = 24'h00_4000;
   logic        clk_sys_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        ce_i = 1'b1;
   logic [7:0]  reg_addr_i = 8'h00;
   logic [31:0] reg_wdata_i = 32'h0000_0000;
   logic        reg_wr_i = 1'b0;
   logic        reg_rd_i = 1'b0;
   logic [31:0] reg_rdata_o;
   logic [23:0] mem_addr_o;
   logic [7:0]  mem_wdata_o;
   logic        mem_we_o;
   logic        mem_req_o;
   logic [7:0]  mem_rdata_i = 8'h00;
   logic        mem_ack_i = 1'b0;
   logic        busy_o;
   logic [7:0]  mem [logic [23:0]];
   int          err_total = 0;
   int          tests_run = 0;
   int          req_cnt = 0;

   pcs_sequencer i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_we_o(mem_we_o), .mem_req_o(mem_req_o),
      .mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i), .busy_o(busy_o));

   initial
   begin
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   function automatic logic [7:0] peek(input logic [23:0] a);
      return mem.exists(a) ? mem[a] : 8'h00;
   endfunction

   // between answers the data line toggles every cycle between its last byte and that byte's inverse
   always @(posedge clk_sys_i)
   begin
      if (mem_req_o && !mem_ack_i)
      begin
         mem_ack_i <= 1'b1;
         mem_rdata_i <= peek(mem_addr_o);
         req_cnt++;
         if (mem_we_o)
            mem[mem_addr_o] = mem_wdata_o;
      end
      else
      begin
         mem_ack_i <= 1'b0;
         mem_rdata_i <= ~mem_rdata_i;
      end
   end

   task automatic conclude;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         err_total++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b0;
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b0;
      #1 chk(reg_rdata_o, exp);
   endtask

   task automatic put(input logic [23:0] a, input logic [23:0] v, input int nb);
      for (int i = 0; i < nb; i++)
         mem[a + 24'(i)] = v[8*i +: 8];
   endtask

   task automatic wait_idle;
      int n = 0;
      do
      begin
         @(posedge clk_sys_i);
         #1 n++;
      end
      while (busy_o !== 1'b0 && n < 500);
      if (n >= 500)
      begin
         err_total++;
         conclude();
      end
   endtask

   task automatic t_reset;
      put(24'hFF_FFFC, 24'h12_3456, 3);
      mem[24'hFF_FFFF] = 8'h9C;
      repeat (3) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      @(posedge clk_sys_i);
      #1 chk(busy_o, 1'b1);
      // a write during the vector fetch must be dropped
      wr(REG_ORIGIN, 32'h0000_1234);
      wait_idle();
      rc(REG_ORIGIN, 32'h0000_0000);
      rc(REG_UPPER, 32'h0000_FFFF);
      rc(REG_CTRL_WORD, 32'h0000_0003);
      rc(REG_PROG_CNT, 32'h0012_3456);
      chk(req_cnt, 4);
      rc(8'h40, 32'h0000_0000);
   endtask

   task automatic t_invoke(input int len, input logic [15:0] cw);
      logic [23:0] stack_top_register = 24'h00_17F4;
      logic [23:0] cp;
      logic [7:0]  e [12];
      int          n0;
      cp = {16'hC35A, 8'(len)};
      e = '{8'h10, 8'h00, 8'h30, 8'h00, 8'h34, 8'h12, 8'h00, 8'h00, 8'h15, 8'h00, cw[7:0], cw[15:8]};
      put(24'h00_0000, cp, 3);
      put(LST, 24'(len), 1);
      put(LST + 24'h1, 24'h00_0020, 2);
      put(LST + 24'h3, 24'h00_0005, 2);
      put(LST + 24'h5, 24'h00_0456, 3);
      put(LST + 24'h8, 24'h00_0900, 3);
      put(LST + 24'hB, 24'h00_0C03, 2);
      put(LST + 24'hD, 24'h00_0777, 3);
      wr(REG_ORIGIN, 32'h0000_0010);
      wr(REG_UPPER, 32'h0000_0030);
      wr(REG_CTRL_WORD, {16'h0000, cw});
      wr(REG_PROG_CNT, 32'h0000_1234);
      wr(REG_PRIMARY, 32'h0000_1500);
      wr(REG_STACK_TOP, 32'h0000_1800);
      wr(REG_OPERAND, {8'h00, LST});
      n0 = req_cnt;
      wr(REG_CMD_STAT, 32'h0000_0001);
      wait_idle();
      for (int i = 0; i < 12; i++)
         chk(peek(stack_top_register + 24'(i)), e[i]);
      for (int i = 0; i < 3; i++)
         chk(peek(24'h00_1000 + 24'(i)), cp[8*i +: 8]);
      for (int i = 0; i < 3; i++)
         chk(peek(24'(i)), stack_top_register[8*i +: 8]);
      rc(REG_ORIGIN, 32'h0000_0030);
      rc(REG_UPPER, 32'h0000_0035);
      rc(REG_PROG_CNT, 32'h0000_3456);
      rc(REG_STACK_TOP, len >= 10 ? 32'h0000_3900 : {8'h00, stack_top_register});
      rc(REG_CTRL_WORD, len >= 12 ? 32'h0000_0C03 : {16'h0000, cw});
      rc(REG_PRIMARY, len >= 15 ? 32'h0000_3777 : 32'h0000_1500);
      rc(REG_OPERAND, {8'h00, LST});
      chk(req_cnt - n0, 22 + len);
      rc(REG_CMD_STAT, 32'h0000_0000);
   endtask

   task automatic t_reject;
      int n0;
      wr(REG_CTRL_WORD, 32'h0000_0000);
      n0 = req_cnt;
      wr(REG_CMD_STAT, 32'h0000_0001);
      repeat (20) @(posedge clk_sys_i);
      chk(req_cnt - n0, 0);
      rc(REG_CMD_STAT, 32'h0000_0002);
      rc(REG_ORIGIN, 32'h0000_0030);
   endtask

   // ce_i low freezes the block: strobes are lost, nothing starts, read data holds
   task automatic t_hold;
      int n0;
      wr(REG_CTRL_WORD, 32'h0000_0001);
      n0 = req_cnt;
      @(posedge clk_sys_i);
      ce_i <= 1'b0;
      wr(REG_ORIGIN, 32'h0000_0077);
      wr(REG_CMD_STAT, 32'h0000_0001);
      rc(REG_CTRL_WORD, 32'h0000_0000);
      repeat (10) @(posedge clk_sys_i);
      ce_i <= 1'b1;
      chk(req_cnt - n0, 0);
      #1 chk(busy_o, 1'b0);
      rc(REG_ORIGIN, 32'h0000_0030);
      rc(REG_CMD_STAT, 32'h0000_0002);
      rc(REG_CTRL_WORD, 32'h0000_0001);
   endtask

   initial
   begin
      int lens [6] = '{7, 9, 10, 12, 14, 15};
      t_reset();
      foreach (lens[i])
         t_invoke(lens[i], (i % 2 == 0) ? 16'h0001 : 16'h0002);
      t_reject();
      t_hold();
      conclude();
   end
endmodule
